//--- core/watchdog_consts.svh
// Constants for the watchdog timer: offsets, fields, codes, times.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef WATCHDOG_CONSTS_SVH
`define WATCHDOG_CONSTS_SVH

`define WD_ADDR_W          8
`define WD_CONTROL_OFFSET  8'h93
`define WD_RESTART_OFFSET  8'h94
`define WD_IRQ_STAT_OFFSET 8'ha0
`define WD_IRQ_MASK_OFFSET 8'ha1

`define WD_BIT_ENABLE      7
`define WD_BIT_NMI_SEL     6
`define WD_BIT_CAUSE       5
`define WD_CLKSEL_HI       4
`define WD_CLKSEL_LO       3
`define WD_BIT_RESERVED    2
`define WD_LEN_HI          1
`define WD_LEN_LO          0
`define WD_CONTROL_RESET   8'h00
`define WD_CONTROL_WMASK   8'hdb

`define WD_KEY_FIRST       8'ha5
`define WD_KEY_SECOND      8'h5a

`define WD_CLK_SYS         2'h0
`define WD_CLK_RTC         2'h1

`define WD_LOG2_LEN0       27
`define WD_LOG2_LEN1       25
`define WD_LOG2_LEN2       22
`define WD_LOG2_LEN3       18
`define WD_CNT_W           28

`define WD_EVT_TIMEOUT     0
`define WD_EVT_KEY_ABORT   1
`define WD_NUM_EVT         2
`define WD_POR_CAUSE       1'b0

`endif

//--- core/watchdog_pkg.sv
// Types shared by the watchdog timer modules.
// Assumes the constants header sits on the include path.
`include "watchdog_consts.svh"

package watchdog_pkg;

   typedef struct packed {
      logic                  write;
      logic                  read;
      logic [`WD_ADDR_W-1:0] addr;
      logic [7:0]            wdata;
   } reg_req_t;

   typedef enum logic [0:0] {KEY_IDLE, KEY_ARMED} key_state_t;

   typedef struct packed {
      logic        enable;
      logic        nmi_sel;
      logic [1:0]  clk_sel;
      logic [1:0]  len_sel;
   } wd_ctrl_t;

endpackage

//--- core/watchdog_counter.sv
// Watchdog count engine: counts ticks, reloads on demand, flags expiry.
// Assumes one clock, synchronous active-low reset, tick as a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_consts.svh"

module watchdog_counter
   import watchdog_pkg::*;
#(
   parameter int CNT_W     = `WD_CNT_W,
   parameter int LOG2_LEN0 = `WD_LOG2_LEN0,
   parameter int LOG2_LEN1 = `WD_LOG2_LEN1,
   parameter int LOG2_LEN2 = `WD_LOG2_LEN2,
   parameter int LOG2_LEN3 = `WD_LOG2_LEN3
) (
   input  wire logic             sys_clk,
   input  wire logic             rstn,
   input  wire logic             run,
   input  wire logic             tick,
   input  wire logic             reload,
   input  wire logic [1:0]       len_sel,
   output logic                  expire,
   output logic [CNT_W-1:0]      count
);

   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic             expire;
   } cnt_state_t;

   cnt_state_t state;
   cnt_state_t next_state;
   logic [CNT_W-1:0] limit;

   always_comb begin
      case (len_sel)
         2'h0:    limit = CNT_W'(1) << LOG2_LEN0;
         2'h1:    limit = CNT_W'(1) << LOG2_LEN1;
         2'h2:    limit = CNT_W'(1) << LOG2_LEN2;
         default: limit = CNT_W'(1) << LOG2_LEN3;
      endcase
   end

   always_comb begin
      next_state = state;
      next_state.expire = 1'b0;
      if (!run || reload) begin
         next_state.count = '0;
      end else if (tick) begin
         if (state.count + CNT_W'(1) >= limit) begin
            next_state.count  = '0;
            next_state.expire = 1'b1;
         end else begin
            next_state.count = state.count + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign expire = state.expire;
   assign count  = state.count;

endmodule // watchdog_counter

`default_nettype wire

//--- core/watchdog_timer.sv
// Watchdog timer: control and restart registers, count, timeout response.
// Assumes a CPU register port with one-cycle strobes, read data next cycle,
// and a debounced RTC tick already synchronous to sys_clk.
//
// What this block does
// - Disabled after reset; bit 7 enables
// - Enable sticks until reset
// - Length field picks 2^27/25/22/18 cycles
// - Clock field picks system or RTC ticks
// - Timeout always sets cause flag bit 5
// - Response bit zero: timeout resets chip
// - Response bit one: timeout raises NMI
// - Cause flag survives own reset only
// - Reset/NMI outputs change on clock edge
// - A5h then 5Ah reloads the counter
// - Any delay allowed between key bytes
// - Restart register write-only, read harmless
// - Bits 5 and 2 read-only, 2 zero
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_consts.svh"

module watchdog_timer
   import watchdog_pkg::*;
#(
   parameter int CNT_W     = `WD_CNT_W,
   parameter int LOG2_LEN0 = `WD_LOG2_LEN0,
   parameter int LOG2_LEN1 = `WD_LOG2_LEN1,
   parameter int LOG2_LEN2 = `WD_LOG2_LEN2,
   parameter int LOG2_LEN3 = `WD_LOG2_LEN3
) (
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   input  wire logic        ext_reset_n,
   input  wire logic        rtc_tick,
   input  wire reg_req_t    reg_req,
   output logic [7:0]       rdata,
   output logic             chip_reset_req,
   output logic             nmi_req,
   output logic             irq
);

   typedef struct packed {
      wd_ctrl_t                  ctrl;
      logic                      cause;
      key_state_t                key;
      logic                      reset_out;
      logic                      nmi_out;
      logic [`WD_NUM_EVT-1:0]    stat;
      logic [`WD_NUM_EVT-1:0]    mask;
      logic [7:0]                rdata;
   } wd_state_t;

   wd_state_t state;
   wd_state_t next_state;

   logic             expire;
   logic             tick;
   logic             key_reload;
   logic             key_abort;
   logic [CNT_W-1:0] count;
   logic             wr_ctrl;
   logic             wr_rst;
   logic [`WD_NUM_EVT-1:0] evt;

   assign wr_ctrl = reg_req.write && reg_req.addr == `WD_CONTROL_OFFSET;
   assign wr_rst  = reg_req.write && reg_req.addr == `WD_RESTART_OFFSET;

   always_comb begin
      case (state.ctrl.clk_sel)
         `WD_CLK_SYS: tick = 1'b1;
         `WD_CLK_RTC: tick = rtc_tick;
         default:     tick = 1'b0;
      endcase
   end

   // armed state waits indefinitely for the second byte
   assign key_reload = wr_rst && state.key == KEY_ARMED
                       && reg_req.wdata == `WD_KEY_SECOND;
   assign key_abort  = wr_rst && state.key == KEY_ARMED
                       && reg_req.wdata != `WD_KEY_SECOND
                       && reg_req.wdata != `WD_KEY_FIRST;

   watchdog_counter #(
      .CNT_W     (CNT_W),
      .LOG2_LEN0 (LOG2_LEN0),
      .LOG2_LEN1 (LOG2_LEN1),
      .LOG2_LEN2 (LOG2_LEN2),
      .LOG2_LEN3 (LOG2_LEN3)
   ) u_counter (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .run     (state.ctrl.enable),
      .tick    (tick),
      .reload  (key_reload),
      .len_sel (state.ctrl.len_sel),
      .expire  (expire),
      .count   (count)
   );

   assign evt = {key_abort, expire};

   always_comb begin
      next_state = state;
      next_state.reset_out = 1'b0;
      next_state.rdata     = 8'h00;
      if (wr_ctrl) begin
         next_state.ctrl.enable  = state.ctrl.enable
                                 | reg_req.wdata[`WD_BIT_ENABLE];
         next_state.ctrl.nmi_sel = reg_req.wdata[`WD_BIT_NMI_SEL];
         next_state.ctrl.clk_sel =
            reg_req.wdata[`WD_CLKSEL_HI:`WD_CLKSEL_LO];
         next_state.ctrl.len_sel = reg_req.wdata[`WD_LEN_HI:`WD_LEN_LO];
      end
      if (wr_rst) begin
         if (reg_req.wdata == `WD_KEY_FIRST) begin
            next_state.key = KEY_ARMED;
         end else begin
            next_state.key = KEY_IDLE;
         end
      end
      if (expire) begin
         next_state.cause = 1'b1;
         if (state.ctrl.nmi_sel) begin
            next_state.nmi_out = 1'b1;
         end else begin
            next_state.reset_out = 1'b1;
         end
      end
      if (reg_req.write && reg_req.addr == `WD_IRQ_MASK_OFFSET) begin
         next_state.mask = reg_req.wdata[`WD_NUM_EVT-1:0];
      end
      if (reg_req.write && reg_req.addr == `WD_IRQ_STAT_OFFSET) begin
         next_state.stat = state.stat & ~reg_req.wdata[`WD_NUM_EVT-1:0];
      end
      next_state.stat = next_state.stat | evt;
      // NMI drops once software reads the control register
      if (reg_req.read && reg_req.addr == `WD_CONTROL_OFFSET) begin
         next_state.nmi_out = expire && state.ctrl.nmi_sel;
      end
      if (reg_req.read) begin
         case (reg_req.addr)
            `WD_CONTROL_OFFSET: begin
               next_state.rdata = {state.ctrl.enable, state.ctrl.nmi_sel,
                                   state.cause, state.ctrl.clk_sel,
                                   1'b0, state.ctrl.len_sel};
            end
            `WD_IRQ_STAT_OFFSET: begin
               next_state.rdata = 8'(state.stat);
            end
            `WD_IRQ_MASK_OFFSET: begin
               next_state.rdata = 8'(state.mask);
            end
            // Restart register reads zero, no side effect
            default: next_state.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         state.ctrl      <= '0;
         state.key       <= KEY_IDLE;
         state.reset_out <= 1'b0;
         state.nmi_out   <= 1'b0;
         state.stat      <= '0;
         state.mask      <= '0;
         state.rdata     <= 8'h00;
         // Own-timeout reset keeps the cause; external clears it
         if (!ext_reset_n) begin
            state.cause <= `WD_POR_CAUSE;
         end else begin
            state.cause <= next_state.cause;
         end
      end else begin
         state <= next_state;
      end
   end

   assign rdata          = state.rdata;
   assign chip_reset_req = state.reset_out;
   assign nmi_req        = state.nmi_out;
   assign irq            = |(state.stat & state.mask);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   sequence s_en_write;
      wr_ctrl && reg_req.wdata[`WD_BIT_ENABLE];
   endsequence

   property p_enable_sets;
      s_en_write |=> state.ctrl.enable;
   endproperty
   a_enable_sets: assert property (p_enable_sets)
      else $error("enable not set by write");

   property p_enable_sticks;
      state.ctrl.enable |=> state.ctrl.enable;
   endproperty
   a_enable_sticks: assert property (p_enable_sticks)
      else $error("enable dropped without reset");

   property p_cause_on_expire;
      expire |=> state.cause;
   endproperty
   a_cause_on_expire: assert property (p_cause_on_expire)
      else $error("cause flag not set on timeout");

   property p_reset_resp;
      expire && !state.ctrl.nmi_sel |=> chip_reset_req && !$rose(nmi_req);
   endproperty
   a_reset_resp: assert property (p_reset_resp)
      else $error("timeout did not request reset");

   property p_nmi_resp;
      expire && state.ctrl.nmi_sel |=> nmi_req && !chip_reset_req;
   endproperty
   a_nmi_resp: assert property (p_nmi_resp)
      else $error("timeout did not raise nmi");

   property p_reserved_zero;
      reg_req.read && reg_req.addr == `WD_CONTROL_OFFSET
         |=> !rdata[`WD_BIT_RESERVED]
             && rdata[`WD_BIT_CAUSE] == $past(state.cause);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("control read wrong");

   sequence s_key_second;
      wr_rst && state.key == KEY_ARMED
      && reg_req.wdata == `WD_KEY_SECOND;
   endsequence

   property p_key_reload;
      s_key_second |=> count == '0;
   endproperty
   a_key_reload: assert property (p_key_reload)
      else $error("key sequence did not reload");

   property p_key_abort;
      wr_rst && reg_req.wdata != `WD_KEY_FIRST |=> state.key == KEY_IDLE;
   endproperty
   a_key_abort: assert property (p_key_abort)
      else $error("bad byte kept sequence armed");

   property p_fresh_start;
      !state.ctrl.enable |=> count == '0;
   endproperty
   a_fresh_start: assert property (p_fresh_start)
      else $error("counter not at start while disabled");

   // Counter advances one step per system clock unless it wraps
   property p_sys_step;
      state.ctrl.enable && state.ctrl.clk_sel == `WD_CLK_SYS && !key_reload
         |=> count == $past(count) + CNT_W'(1) || count == '0;
   endproperty
   a_sys_step: assert property (p_sys_step)
      else $error("count did not follow system clock");

   property p_rtc_hold;
      state.ctrl.enable && state.ctrl.clk_sel == `WD_CLK_RTC && !rtc_tick
         && !key_reload |=> $stable(count);
   endproperty
   a_rtc_hold: assert property (p_rtc_hold)
      else $error("count moved without an rtc tick");

   property p_key_arm;
      wr_rst && reg_req.wdata == `WD_KEY_FIRST |=> state.key == KEY_ARMED;
   endproperty
   a_key_arm: assert property (p_key_arm)
      else $error("first key byte did not arm");

   property p_abort_flag;
      key_abort |=> state.stat[`WD_EVT_KEY_ABORT];
   endproperty
   a_abort_flag: assert property (p_abort_flag)
      else $error("abandoned key sequence not flagged");

   property p_restart_read;
      reg_req.read && reg_req.addr == `WD_RESTART_OFFSET
         |=> rdata == 8'h00 && $stable(state.key);
   endproperty
   a_restart_read: assert property (p_restart_read)
      else $error("restart read had an effect");

   property p_reset_pulse;
      chip_reset_req |=> !chip_reset_req;
   endproperty
   a_reset_pulse: assert property (p_reset_pulse)
      else $error("reset request longer than one cycle");

   // NMI is a level: it stands until software reads control
   property p_nmi_holds;
      nmi_req && !(reg_req.read && reg_req.addr == `WD_CONTROL_OFFSET)
         |=> nmi_req;
   endproperty
   a_nmi_holds: assert property (p_nmi_holds)
      else $error("nmi dropped without acknowledge");

   property p_nmi_ack;
      reg_req.read && reg_req.addr == `WD_CONTROL_OFFSET && !expire
         |=> !nmi_req;
   endproperty
   a_nmi_ack: assert property (p_nmi_ack)
      else $error("nmi not cleared by control read");

   // Cause flag checks must run while reset is low
   property p_cause_kept;
      disable iff (1'b0)
      !rstn && ext_reset_n && state.cause |=> state.cause;
   endproperty
   a_cause_kept: assert property (p_cause_kept)
      else $error("own reset lost the cause flag");

   property p_cause_cleared;
      disable iff (1'b0)
      !rstn && !ext_reset_n |=> !state.cause;
   endproperty
   a_cause_cleared: assert property (p_cause_cleared)
      else $error("external reset kept the cause flag");

endmodule // watchdog_timer

`default_nettype wire

//--- verif/cpu_reset_model.sv
// CPU-side reset model: turns a watchdog reset request into a chip reset.
// Assumes chip_reset_req is a one-cycle pulse on sys_clk.
`timescale 1ns/1ps
`default_nettype none

module cpu_reset_model #(
   parameter int HOLD = 4
) (
   input  wire logic sys_clk,
   input  wire logic chip_reset_req,
   output logic      wd_rstn
);
   int hold_cnt = 0;
   always @(posedge sys_clk) begin
      if (chip_reset_req) begin
         hold_cnt <= HOLD;
      end else if (hold_cnt > 0) begin
         hold_cnt <= hold_cnt - 1;
      end
   end
   // Chip held in reset while the count runs
   assign wd_rstn = (hold_cnt == 0);
endmodule // cpu_reset_model
`default_nettype wire

//--- verif/watchdog_timer_bench.sv
// Self-checking bench for the watchdog timer.
// Assumes the package and header compiled first; one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module watchdog_timer_bench;
   import watchdog_pkg::*;
   localparam int LIMIT = 40000;
   // Short lengths keep the run brief; codes keep their order
   localparam int L0 = 12;
   localparam int L1 = 11;
   localparam int L2 = 10;
   localparam int L3 = 9;
   localparam int T0 = 1 << L0;
   localparam int T1 = 1 << L1;
   localparam int T2 = 1 << L2;
   localparam int T3 = 1 << L3;
   localparam int RTC_DIV = 7;
   logic       sys_clk = 0;
   logic       bench_rstn = 0;
   logic       ext_reset_n = 0;
   logic       rtc_tick = 0;
   reg_req_t   req = '0;
   wire logic  rstn;
   wire logic  wd_rstn;
   logic [7:0] rdata;
   logic       chip_reset_req;
   logic       nmi_req;
   logic       irq;
   int         cyc = 0;
   int         error_cnt = 0;
   int         n_compared = 0;

   always #5 sys_clk = ~sys_clk;
   assign rstn = bench_rstn & wd_rstn;

   watchdog_timer #(
      .LOG2_LEN0 (L0),
      .LOG2_LEN1 (L1),
      .LOG2_LEN2 (L2),
      .LOG2_LEN3 (L3)
   ) uut (
      .sys_clk        (sys_clk),
      .rstn           (rstn),
      .ext_reset_n    (ext_reset_n),
      .rtc_tick       (rtc_tick),
      .reg_req        (req),
      .rdata          (rdata),
      .chip_reset_req (chip_reset_req),
      .nmi_req        (nmi_req),
      .irq            (irq)
   );

   cpu_reset_model cpu (
      .sys_clk        (sys_clk),
      .chip_reset_req (chip_reset_req),
      .wd_rstn        (wd_rstn)
   );

   task automatic results;
      $display("compared=%0d errors=%0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      rtc_tick <= (cyc % RTC_DIV == 0);
      if (cyc == LIMIT) begin
         error_cnt++;
         results();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Waits for the chosen response output; cycles since t0
   task automatic wait_out(input logic nmi, input time t0, output int el);
      int n;
      n = 0;
      while ((nmi ? nmi_req : chip_reset_req) !== 1'b1 && n < 9000) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      el = int'(($time - t0) / 10);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      req <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
      @(posedge sys_clk);
      req <= '0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      req <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
      @(posedge sys_clk);
      req <= '0;
      #1;
      chk(rdata, exp);
   endtask

   // Low ext_reset_n marks an external reset, which clears the cause flag
   task automatic do_reset(input logic ext);
      @(posedge sys_clk);
      ext_reset_n <= ext;
      bench_rstn <= 1'b0;
      repeat (16) @(posedge sys_clk);
      bench_rstn <= 1'b1;
      ext_reset_n <= 1'b1;
   endtask

   task automatic t_reset_vals;
      rd(8'h93, 8'h00);
      rd(8'h94, 8'h00);
      rd(8'h50, 8'h00);
   endtask

   // Clock select 11 keeps the count still for the 5Bh and FFh writes; the 00h write starts it on the system clock
   task automatic t_ctrl;
      wr(8'h93, 8'h5b);
      rd(8'h93, 8'h5b);
      wr(8'h93, 8'hff);
      rd(8'h93, 8'hdb);
      wr(8'h93, 8'h00);
      rd(8'h93, 8'h80);
      do_reset(1'b0);
      rd(8'h93, 8'h00);
   endtask

   task automatic t_irq;
      wr(8'h94, 8'ha5);
      wr(8'h94, 8'h00);
      rd(8'ha0, 8'h02);
      chk({7'h0, irq}, 8'h00);
      wr(8'ha1, 8'h02);
      #1;
      chk({7'h0, irq}, 8'h01);
      wr(8'ha0, 8'h02);
      #1;
      chk({7'h0, irq}, 8'h00);
      rd(8'ha0, 8'h00);
      wr(8'ha1, 8'h00);
   endtask

   // Longest length on the system clock, reset response
   task automatic t_len0;
      time t0;
      int  el;
      wr(8'h93, 8'h80);
      t0 = $time;
      wait_out(1'b0, t0, el);
      chk({7'h0, (el >= T0 - 2 && el <= T0 + 4)}, 8'h01);
      chk({7'h0, nmi_req}, 8'h00);
      repeat (12) @(posedge sys_clk);
      rd(8'h93, 8'h20);
   endtask

   // NMI response on the system clock, then on RTC ticks
   task automatic t_nmi;
      time t0;
      int  el;
      do_reset(1'b0);
      wr(8'h93, 8'hc1);
      t0 = $time;
      wait_out(1'b1, t0, el);
      chk({7'h0, (el >= T1 - 2 && el <= T1 + 4)}, 8'h01);
      chk({7'h0, chip_reset_req}, 8'h00);
      rd(8'h93, 8'he1);
      chk({7'h0, nmi_req}, 8'h00);
      wr(8'h93, 8'hca);
      wr(8'h94, 8'ha5);
      repeat (20) @(posedge sys_clk);
      wr(8'h94, 8'h5a);
      t0 = $time;
      wait_out(1'b1, t0, el);
      chk({7'h0, (el >= T2 * RTC_DIV - 8 && el <= T2 * RTC_DIV + 8)},
          8'h01);
      chk({7'h0, chip_reset_req}, 8'h00);
      rd(8'h93, 8'hea);
      do_reset(1'b0);
   endtask

   // Only the first key pair may reload; the broken pair must not
   task automatic t_timeout;
      time t_svc;
      int  el;
      wr(8'h93, 8'h83);
      repeat (300) @(posedge sys_clk);
      wr(8'h94, 8'ha5);
      wr(8'h94, 8'h5a);
      t_svc = $time;
      repeat (300) @(posedge sys_clk);
      rd(8'h94, 8'h00);
      wr(8'h94, 8'ha5);
      wr(8'h94, 8'h11);
      wr(8'h94, 8'h5a);
      wait_out(1'b0, t_svc, el);
      chk({7'h0, (el >= T3 - 2 && el <= T3 + 4)}, 8'h01);
      chk({7'h0, chip_reset_req}, 8'h01);
      chk({7'h0, nmi_req}, 8'h00);
      repeat (12) @(posedge sys_clk);
      rd(8'h93, 8'h20);
      do_reset(1'b0);
      rd(8'h93, 8'h00);
   endtask

   initial begin
      do_reset(1'b0);
      t_reset_vals();
      t_ctrl();
      t_irq();
      t_len0();
      t_nmi();
      t_timeout();
      results();
   end
endmodule // watchdog_timer_bench
`default_nettype wire
